// ==== design/sccs_top.sv ====
/*
 * Scan channel selection and per-channel open/short/load correction,
 * with an AHB-Lite register slave.
 * Assumes the measuring core pulses analog_done_in, meas_done_in and
 * cal_store_valid for one cycle, and that all pins are clk-synchronous.
 */
`timescale 1ns/1ns

// Notes on behaviour
// - With correction off, ignore channel inputs and drive both done outputs low.
// - Outside trigger mode accepts the trigger input regardless of correction state.
// - Channel lines are active-low binary, line seven most significant.
// - Channel lines count only while the channel strobe is low.
// - Scanned channel number takes effect only at a trigger.
// - Channel chosen by software becomes active at once.
// - Hold 256 correction sets and recall the active channel's set.
// - Apply the channel's own open, short and load correction.
// - Measured correction data goes into the active channel's slot.
// - Single mode stores reference for one channel, common mode for all.
// - Correction data is never cleared, not even by reset.
// - One enable switches both scan interface and multi-channel correction.
// - Stepping moves the channel by plus or minus one or ten.
// - With correction on, results use the active channel's stored data.
// - Viewing shows the set of the channel selected beforehand.
// - Analog-done asserts when analog measurement finishes.
// - Measurement-end asserts only once data and comparison are valid; it is held asserted (low) while correction is off.
// - Slash-named scan signals are active low on both sides.
module sccs_top #(
    parameter int unsigned CHANNELS = sccs_pkg::NUM_CHANNELS,
    parameter int unsigned W = sccs_pkg::CORR_W
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, words only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    output logic [31:0] hrdata, // AHB read data
    input wire logic [7:0] channel_number_n, // Scanner channel lines, active low
    input wire logic channel_strobe_n, // Channel valid, active low
    input wire logic outside_trigger_in, // Outside trigger, rising edge
    output logic index_n, // Analog measurement done, active low
    output logic measurement_end_n, // Measurement end, active low
    output logic meas_start, // Start pulse to measuring core
    input wire logic analog_done_in, // Core: analog phase finished
    input wire logic meas_done_in, // Core: data and comparison valid
    input wire logic cal_store_valid, // Core: measured correction value
    input wire logic [1:0] cal_kind, // Core: open, short or load
    input wire logic [W-1:0] cal_value, // Core: correction value
    input wire logic result_valid, // Core: raw result strobe
    input wire logic [W-1:0] raw_result, // Core: raw result
    output logic corr_valid, // Corrected result strobe
    output logic [W-1:0] corr_result, // Corrected result
    output logic [7:0] active_channel // Active channel number
);

    localparam int unsigned KINDS = 4;

    // Correction store, deliberately outside any reset so it survives
    logic [W-1:0] corr_mem [KINDS][CHANNELS];

    logic [2:0] ctrl_reg;
    logic [7:0] channel_reg, fill_idx_reg;
    logic [1:0] corr_sel_reg;
    logic [W-1:0] fill_value_reg;
    sccs_pkg::sccs_state_e state_reg;
    sccs_pkg::sccs_bus_req_s req_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
    logic index_reg, eom_reg, running_reg, start_reg, corr_valid_reg;
    logic [W-1:0] corr_result_reg;

    logic mc_en, outside_mode, common_mode, addr_take, wr_now;
    logic outside_edge, soft_trig, trigger;
    sccs_pkg::sccs_corr_wr_s mem_wr;
    logic [W-1:0] corr_calc;

    assign mc_en = ctrl_reg[sccs_pkg::CTRL_MC_EN_BIT];
    assign outside_mode = ctrl_reg[sccs_pkg::CTRL_OUTSIDE_BIT];
    assign common_mode = ctrl_reg[sccs_pkg::CTRL_COMMON_BIT];

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    assign addr_take = hsel && hready && htrans[1];
    assign wr_now = req_reg.valid && req_reg.write;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_reg <= '0;
        end
        else if (hready)
        begin
            req_reg.valid <= addr_take;
            req_reg.write <= hwrite;
            req_reg.addr <= haddr[7:0];
        end
    end

    // Read data is latched at the address edge so the data phase has no wait
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hrdata_reg <= 32'h0;
        end
        else if (addr_take && !hwrite)
        begin
            case (haddr[7:0])
                sccs_pkg::OFS_CTRL: hrdata_reg <= {29'h0, ctrl_reg};
                sccs_pkg::OFS_CHANNEL: hrdata_reg <= {24'h0, channel_reg};
                sccs_pkg::OFS_CORR_SEL: hrdata_reg <= {30'h0, corr_sel_reg};
                // View uses the channel chosen before the read
                sccs_pkg::OFS_CORR_VIEW:
                    hrdata_reg <= 32'(corr_mem[corr_sel_reg][channel_reg]);
                sccs_pkg::OFS_STATUS: hrdata_reg <= {28'h0, running_reg, eom_reg,
                    index_reg, state_reg == sccs_pkg::SCCS_ST_FILL};
                default: hrdata_reg <= 32'h0;
            endcase
        end
    end

    // Ready drops while a common-mode fill sweeps the store
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hreadyout_reg <= 1'b1;
        end
        else
        begin
            hreadyout_reg <= !((state_reg == sccs_pkg::SCCS_ST_FILL &&
                fill_idx_reg != 8'(CHANNELS - 1)) ||
                (wr_now && reg_hit(req_reg.addr, sccs_pkg::OFS_CORR_WR) &&
                hwdata[17:16] == sccs_pkg::KIND_REF && common_mode));
        end
    end

    // One bit enables both scan interface and correction
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_reg <= sccs_pkg::CTRL_RESET;
            corr_sel_reg <= sccs_pkg::KIND_OPEN;
        end
        else if (wr_now && reg_hit(req_reg.addr, sccs_pkg::OFS_CTRL))
        begin
            ctrl_reg <= hwdata[2:0];
        end
        else if (wr_now && reg_hit(req_reg.addr, sccs_pkg::OFS_CORR_SEL))
        begin
            corr_sel_reg <= hwdata[1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_s3_reg <= 1'b0;
        end
        else
        begin
            trig_s1_reg <= outside_trigger_in;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
        end
    end

    assign outside_edge = trig_s2_reg && !trig_s3_reg;
    assign soft_trig = wr_now && reg_hit(req_reg.addr, sccs_pkg::OFS_TRIG) && hwdata[0];
    assign trigger = outside_mode ? outside_edge : soft_trig;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            channel_reg <= sccs_pkg::CHANNEL_RESET;
        end
        else if (wr_now && reg_hit(req_reg.addr, sccs_pkg::OFS_CHANNEL))
        begin
            channel_reg <= hwdata[7:0];
        end
        else if (wr_now && reg_hit(req_reg.addr, sccs_pkg::OFS_STEP))
        begin
            // Steps wrap modulo 256
            case (hwdata[1:0])
                sccs_pkg::STEP_UP_1: channel_reg <= channel_reg + sccs_pkg::STEP_SMALL;
                sccs_pkg::STEP_DOWN_1: channel_reg <= channel_reg - sccs_pkg::STEP_SMALL;
                sccs_pkg::STEP_UP_10: channel_reg <= channel_reg + sccs_pkg::STEP_LARGE;
                sccs_pkg::STEP_DOWN_10: channel_reg <= channel_reg - sccs_pkg::STEP_LARGE;
                default: channel_reg <= channel_reg;
            endcase
        end
        else if (trigger && mc_en && !channel_strobe_n)
        begin
            // Lines sampled in the edge cycle, inverted to binary
            channel_reg <= ~channel_number_n;
        end
        // Strobe high or correction off: old channel kept
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            start_reg <= 1'b0;
            running_reg <= 1'b0;
        end
        else
        begin
            start_reg <= trigger;
            if (trigger)
            begin
                running_reg <= 1'b1;
            end
            else if (meas_done_in)
            begin
                running_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            index_reg <= 1'b0;
            eom_reg <= 1'b0;
        end
        else
        begin
            if (analog_done_in)
            begin
                index_reg <= 1'b1;
            end
            else if (trigger)
            begin
                index_reg <= 1'b0;
            end
            if (meas_done_in)
            begin
                eom_reg <= 1'b1;
            end
            else if (trigger)
            begin
                eom_reg <= 1'b0;
            end
        end
    end

    // Pins idle high, low when asserted; held low while correction is off
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            index_n <= 1'b0;
            measurement_end_n <= 1'b0;
        end
        else
        begin
            index_n <= mc_en ? !(index_reg || analog_done_in) : 1'b0;
            measurement_end_n <= mc_en ? !(eom_reg || meas_done_in) : 1'b0;
        end
    end

    // Store writes: bus entry has priority over a measured value in the same cycle
    always_comb
    begin
        mem_wr = '0;
        if (wr_now && reg_hit(req_reg.addr, sccs_pkg::OFS_CORR_WR))
        begin
            mem_wr.valid = 1'b1;
            mem_wr.kind = hwdata[17:16];
            mem_wr.value = hwdata[W-1:0];
        end
        else if (cal_store_valid && mc_en)
        begin
            mem_wr.valid = 1'b1;
            mem_wr.kind = cal_kind;
            mem_wr.value = cal_value;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= sccs_pkg::SCCS_ST_IDLE;
            fill_idx_reg <= 8'h00;
            fill_value_reg <= '0;
        end
        else
        begin
            case (state_reg)
                sccs_pkg::SCCS_ST_IDLE:
                begin
                    if (mem_wr.valid && mem_wr.kind == sccs_pkg::KIND_REF && common_mode)
                    begin
                        state_reg <= sccs_pkg::SCCS_ST_FILL;
                        fill_idx_reg <= 8'h00;
                        fill_value_reg <= mem_wr.value;
                    end
                end
                sccs_pkg::SCCS_ST_FILL:
                begin
                    fill_idx_reg <= fill_idx_reg + 8'h01;
                    if (fill_idx_reg == 8'(CHANNELS - 1))
                    begin
                        state_reg <= sccs_pkg::SCCS_ST_IDLE;
                    end
                end
                default: state_reg <= sccs_pkg::SCCS_ST_IDLE;
            endcase
        end
    end

    // No reset branch: the store is never cleared
    always_ff @(posedge clk)
    begin
        if (state_reg == sccs_pkg::SCCS_ST_FILL)
        begin
            corr_mem[sccs_pkg::KIND_REF][fill_idx_reg] <= fill_value_reg;
        end
        else if (mem_wr.valid && !(mem_wr.kind == sccs_pkg::KIND_REF && common_mode))
        begin
            corr_mem[mem_wr.kind][channel_reg] <= mem_wr.value;
        end
    end

    // Result less open and short offsets, plus reference minus measured load
    assign corr_calc = W'(raw_result - corr_mem[sccs_pkg::KIND_OPEN][channel_reg]
        - corr_mem[sccs_pkg::KIND_SHORT][channel_reg]
        + corr_mem[sccs_pkg::KIND_REF][channel_reg]
        - corr_mem[sccs_pkg::KIND_LOAD][channel_reg]);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            corr_valid_reg <= 1'b0;
            corr_result_reg <= '0;
        end
        else
        begin
            corr_valid_reg <= result_valid;
            if (result_valid)
            begin
                corr_result_reg <= mc_en ? corr_calc : raw_result;
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign meas_start = start_reg;
    assign corr_valid = corr_valid_reg;
    assign corr_result = corr_result_reg;
    assign active_channel = channel_reg;

    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8]};

endmodule : sccs_top

// ==== common/sccs_pkg.sv ====
/*
 * Constants, register map and carrier types for the scan channel
 * correction select block.
 * Assumes a 32-bit AHB-Lite bus and one 50 MHz clock.
 */
package sccs_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned NUM_CHANNELS = 256;
    localparam int unsigned CORR_W = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHANNEL = 8'h04;
    localparam logic [7:0] OFS_STEP = 8'h08;
    localparam logic [7:0] OFS_CORR_SEL = 8'h0c;
    localparam logic [7:0] OFS_CORR_WR = 8'h10;
    localparam logic [7:0] OFS_CORR_VIEW = 8'h14;
    localparam logic [7:0] OFS_TRIG = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // Control register fields
    localparam int unsigned CTRL_MC_EN_BIT = 0;
    localparam int unsigned CTRL_OUTSIDE_BIT = 1;
    localparam int unsigned CTRL_COMMON_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Status register fields
    localparam int unsigned STAT_FILL_BIT = 0;
    localparam int unsigned STAT_INDEX_BIT = 1;
    localparam int unsigned STAT_EOM_BIT = 2;
    localparam int unsigned STAT_RUN_BIT = 3;

    localparam logic [7:0] CHANNEL_RESET = 8'h00;
    localparam logic [7:0] STEP_SMALL = 8'h01;
    localparam logic [7:0] STEP_LARGE = 8'h0a;

    // Step command codes
    localparam logic [1:0] STEP_UP_1 = 2'h0;
    localparam logic [1:0] STEP_DOWN_1 = 2'h1;
    localparam logic [1:0] STEP_UP_10 = 2'h2;
    localparam logic [1:0] STEP_DOWN_10 = 2'h3;

    // Correction data kinds
    localparam logic [1:0] KIND_OPEN = 2'h0;
    localparam logic [1:0] KIND_SHORT = 2'h1;
    localparam logic [1:0] KIND_LOAD = 2'h2;
    localparam logic [1:0] KIND_REF = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [0:0] {
        SCCS_ST_IDLE = 1'b0,
        SCCS_ST_FILL = 1'b1
    } sccs_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } sccs_bus_req_s;

    typedef struct packed {
        logic valid;
        logic [1:0] kind;
        logic [CORR_W-1:0] value;
    } sccs_corr_wr_s;

endpackage : sccs_pkg

// ==== verif/sccs_checker.sv ====
/*
 * Port-level checker for sccs_top, bound into every instance.
 * Assumes hready is the slave's own hreadyout (single slave).
 */
`timescale 1ns/1ns
module sccs_checker #(
    parameter int unsigned CHANNELS = 256,
    parameter int unsigned W = 16
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic hsel, // Slave select
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic [7:0] channel_number_n, // Channel lines
    input wire logic channel_strobe_n, // Channel valid
    input wire logic index_n, // Analog done
    input wire logic measurement_end_n, // Measurement end
    input wire logic meas_start, // Start pulse
    input wire logic analog_done_in, // Core analog done
    input wire logic meas_done_in, // Core data valid
    input wire logic result_valid, // Raw result strobe
    input wire logic corr_valid, // Corrected strobe
    input wire logic [7:0] active_channel // Active channel
);
    logic wr_take;
    logic [2:0] wr_hist;
    logic bus_moved;

    // Software writes may move the channel or the flags without a trigger
    assign wr_take = hsel && hready && htrans[1] && hwrite;
    assign bus_moved = |wr_hist;

    always_ff @(posedge clk)
    begin
        wr_hist <= rst ? 3'h0 : {wr_hist[1:0], wr_take};
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    scan_decode_a: assert property (meas_start && !bus_moved && $changed(active_channel)
        |-> active_channel == ~$past(channel_number_n) && !$past(channel_strobe_n))
        else $error("bad scan channel");
    strobe_keep_a: assert property (meas_start && !bus_moved && $past(channel_strobe_n)
        |-> $stable(active_channel)) else $error("strobe high moved channel");
    trigger_only_a: assert property ($changed(active_channel)
        |-> meas_start || bus_moved) else $error("channel moved untriggered");
    index_done_a: assert property (analog_done_in |=> !index_n)
        else $error("index not shown");
    eom_done_a: assert property (meas_done_in |=> !measurement_end_n)
        else $error("end not shown");
    index_hold_a: assert property ($rose(index_n) |-> $past(meas_start) || bus_moved)
        else $error("index left early");
    eom_hold_a: assert property ($rose(measurement_end_n) |-> $past(meas_start) || bus_moved)
        else $error("end left early");
    start_pulse_a: assert property (meas_start |=> !meas_start)
        else $error("long start");
    corr_follow_a: assert property (corr_valid == $past(result_valid))
        else $error("late corrected strobe");
    fill_bound_a: assert property (!hreadyout |-> ##[1:260] hreadyout)
        else $error("fill stall too long");

    cover property (meas_start && $changed(active_channel));
    cover property ($fell(hreadyout));
    cover property ($rose(index_n));
endmodule : sccs_checker

bind sccs_top sccs_checker #(.CHANNELS(CHANNELS), .W(W)) i_sccs_checker (.clk(clk), .rst(rst),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .channel_number_n(channel_number_n), .channel_strobe_n(channel_strobe_n),
    .index_n(index_n), .measurement_end_n(measurement_end_n), .meas_start(meas_start),
    .analog_done_in(analog_done_in), .meas_done_in(meas_done_in),
    .result_valid(result_valid), .corr_valid(corr_valid), .active_channel(active_channel));

// ==== verif/sccs_scanner_model.sv ====
/*
 * Scanner controller model driving channel lines, strobe and trigger.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ns
module sccs_scanner_model (
    input wire logic clk, // System clock
    output logic [7:0] channel_number_n, // Channel lines, active low
    output logic channel_strobe_n, // Channel valid, active low
    output logic outside_trigger_in // Outside trigger
);
    int hold_cnt = 0;

    initial
    begin
        channel_number_n = 8'hff;
        channel_strobe_n = 1'b1;
        outside_trigger_in = 1'b0;
    end

    task automatic present(input logic [7:0] ch, input logic valid, input int gap);
        channel_strobe_n <= 1'b1;
        @(posedge clk);
        channel_number_n <= ~ch;
        repeat (gap) @(posedge clk);
        channel_strobe_n <= ~valid;
        @(posedge clk);
    endtask : present

    task automatic fire();
        outside_trigger_in <= 1'b1;
        hold_cnt <= 4;
    endtask : fire

    // Released lines show the inverse, so a stale number is never latched
    always @(posedge clk)
    begin
        if (hold_cnt != 0)
            hold_cnt <= hold_cnt - 1;
        if (hold_cnt == 1)
        begin
            outside_trigger_in <= 1'b0;
            channel_strobe_n <= 1'b1;
            channel_number_n <= ~channel_number_n;
        end
    end
endmodule : sccs_scanner_model

// ==== verif/sccs_top_tb.sv ====
/*
 * Bench for sccs_top playing bus master and core.
 * Assumes the scanner model and checker are compiled too.
 */
`timescale 1ns/1ns
module sccs_top_tb;
    logic clk, hreadyout, hresp, index_n, measurement_end_n, meas_start, corr_valid;
    logic rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, analog_done_in = 1'b0, meas_done_in = 1'b0;
    logic cal_store_valid = 1'b0, result_valid = 1'b0, channel_strobe_n, outside_trigger_in;
    logic [1:0] htrans = 2'h0, cal_kind = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] cal_value = 16'h0, raw_result = 16'h0, corr_result;
    logic [7:0] channel_number_n, active_channel;
    logic [1:0] step_cmd [4] = '{sccs_pkg::STEP_DOWN_1, sccs_pkg::STEP_UP_1,
        sccs_pkg::STEP_UP_10, sccs_pkg::STEP_DOWN_10};
    logic [7:0] step_exp [4] = '{8'hff, 8'h00, 8'h0a, 8'h00};
    logic [15:0] corr_val [4] = '{16'h0005, 16'h0003, 16'h0002, 16'h0064};
    int fail_count = 0, checks = 0;

    sccs_top i_sccs_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .channel_number_n(channel_number_n), .channel_strobe_n(channel_strobe_n),
        .outside_trigger_in(outside_trigger_in), .index_n(index_n),
        .measurement_end_n(measurement_end_n), .meas_start(meas_start),
        .analog_done_in(analog_done_in), .meas_done_in(meas_done_in),
        .cal_store_valid(cal_store_valid), .cal_kind(cal_kind), .cal_value(cal_value),
        .result_valid(result_valid), .raw_result(raw_result), .corr_valid(corr_valid),
        .corr_result(corr_result), .active_channel(active_channel));
    sccs_scanner_model i_sccs_scanner_model (.clk(clk), .channel_number_n(channel_number_n),
        .channel_strobe_n(channel_strobe_n), .outside_trigger_in(outside_trigger_in));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", w, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // Waits for start pulse or bus ready; a hang ends the run
    task automatic wait_for(input logic start);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((start ? meas_start : hreadyout) !== 1'b1 && n < 1000);
        checks++;
        if ((start ? meas_start : hreadyout) !== 1'b1)
        begin
            fail_count++;
            $display("unexpected wait %b: expected 1, seen none", start);
            summarize();
        end
    endtask : wait_for

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= sccs_pkg::HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_for(1'b0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_for(1'b0);
        rd = hrdata;
    endtask : bus

    task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(w, rd, exp);
    endtask : rchk

    task automatic pulse(input logic analog);
        analog_done_in <= analog;
        meas_done_in <= ~analog;
        @(posedge clk);
        analog_done_in <= 1'b0;
        meas_done_in <= 1'b0;
        @(posedge clk);
    endtask : pulse

    task automatic result(input logic [15:0] raw, input logic [15:0] exp);
        result_valid <= 1'b1;
        raw_result <= raw;
        @(posedge clk);
        result_valid <= 1'b0;
        @(posedge clk);
        check("corr_valid", corr_valid, 1'b1);
        check("corr_result", corr_result, exp);
    endtask : result

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("active_channel", active_channel, 8'h00);
        check("index_n", index_n, 1'b0);
        check("measurement_end_n", measurement_end_n, 1'b0);
        rchk("ctrl", sccs_pkg::OFS_CTRL, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
        $display("test reset done");
        bus(1'b1, sccs_pkg::OFS_CTRL, 32'h2);
        i_sccs_scanner_model.present(8'h05, 1'b1, 0);
        i_sccs_scanner_model.fire();
        wait_for(1'b1);
        @(posedge clk);
        check("active_channel", active_channel, 8'h00);
        pulse(1'b1);
        check("index_n", index_n, 1'b0);
        result(16'h1234, 16'h1234);
        $display("test disabled done");
        bus(1'b1, sccs_pkg::OFS_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        check("index_n", index_n, 1'b0);
        check("measurement_end_n", measurement_end_n, 1'b1);
        i_sccs_scanner_model.present(8'h80, 1'b1, 3);
        repeat (4) @(posedge clk);
        check("active_channel", active_channel, 8'h00);
        i_sccs_scanner_model.fire();
        wait_for(1'b1);
        check("active_channel", active_channel, 8'h80);
        pulse(1'b1);
        check("index_n", index_n, 1'b0);
        check("measurement_end_n", measurement_end_n, 1'b1);
        pulse(1'b0);
        check("measurement_end_n", measurement_end_n, 1'b0);
        i_sccs_scanner_model.present(8'h03, 1'b0, 0);
        i_sccs_scanner_model.fire();
        wait_for(1'b1);
        check("active_channel", active_channel, 8'h80);
        @(posedge clk);
        check("index_n", index_n, 1'b1);
        i_sccs_scanner_model.present(8'h03, 1'b1, 0);
        i_sccs_scanner_model.fire();
        wait_for(1'b1);
        check("active_channel", active_channel, 8'h03);
        $display("test scan select done");
        bus(1'b1, sccs_pkg::OFS_CHANNEL, 32'h0);
        @(posedge clk);
        check("active_channel", active_channel, 8'h00);
        foreach (step_cmd[i])
        begin
            bus(1'b1, sccs_pkg::OFS_STEP, {30'h0, step_cmd[i]});
            @(posedge clk);
            check("step", active_channel, step_exp[i]);
        end
        $display("test stepping done");
        bus(1'b1, sccs_pkg::OFS_CHANNEL, 32'h1);
        for (int k = 0; k < 4; k++)
            bus(1'b1, sccs_pkg::OFS_CORR_WR, {14'h0, k[1:0], corr_val[k]});
        bus(1'b1, sccs_pkg::OFS_CHANNEL, 32'h2);
        for (int k = 1; k < 4; k++)
            bus(1'b1, sccs_pkg::OFS_CORR_WR, {14'h0, k[1:0], 16'h0000});
        cal_kind <= sccs_pkg::KIND_OPEN;
        cal_value <= 16'h0009;
        cal_store_valid <= 1'b1;
        @(posedge clk);
        cal_store_valid <= 1'b0;
        result(16'h03e8, 16'h03df);
        bus(1'b1, sccs_pkg::OFS_CORR_SEL, {30'h0, sccs_pkg::KIND_OPEN});
        rchk("view ch2", sccs_pkg::OFS_CORR_VIEW, 32'h9);
        bus(1'b1, sccs_pkg::OFS_CHANNEL, 32'h1);
        result(16'h03e8, 16'h0442);
        rchk("view ch1", sccs_pkg::OFS_CORR_VIEW, 32'h5);
        $display("test correction done");
        bus(1'b1, sccs_pkg::OFS_CTRL, 32'h7);
        bus(1'b1, sccs_pkg::OFS_CORR_WR, {14'h0, sccs_pkg::KIND_REF, 16'h0032});
        bus(1'b1, sccs_pkg::OFS_CTRL, 32'h3);
        bus(1'b1, sccs_pkg::OFS_CORR_SEL, {30'h0, sccs_pkg::KIND_REF});
        rchk("ref ch1", sccs_pkg::OFS_CORR_VIEW, 32'h32);
        bus(1'b1, sccs_pkg::OFS_CHANNEL, 32'h2);
        bus(1'b1, sccs_pkg::OFS_CORR_WR, {14'h0, sccs_pkg::KIND_REF, 16'h0046});
        rchk("ref ch2", sccs_pkg::OFS_CORR_VIEW, 32'h46);
        bus(1'b1, sccs_pkg::OFS_CHANNEL, 32'h1);
        rchk("ref ch1 kept", sccs_pkg::OFS_CORR_VIEW, 32'h32);
        $display("test load reference done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b1, sccs_pkg::OFS_CTRL, 32'h1);
        bus(1'b1, sccs_pkg::OFS_CHANNEL, 32'h1);
        bus(1'b1, sccs_pkg::OFS_CORR_SEL, {30'h0, sccs_pkg::KIND_OPEN});
        rchk("kept open", sccs_pkg::OFS_CORR_VIEW, 32'h5);
        bus(1'b1, sccs_pkg::OFS_TRIG, 32'h1);
        wait_for(1'b1);
        check("active_channel", active_channel, 8'h01);
        $display("test persistence done");
        summarize();
    end
endmodule : sccs_top_tb
